// >>> spi_master_slave_ports.sv
// SPI slave port and SPI master port, each a plain byte pipe in both directions.
// Assumes configuration inputs stay stable while a transfer is running.
//
// Contract
// - Four modes from polarity and phase
// - Clock idles at polarity level
// - Mode 0: sample rising, change falling
// - Mode 1: sample falling, change rising
// - Mode 2: sample falling, change rising
// - Mode 3: sample rising, change falling
// - Slave moves bytes, no handshake
// - Deselect aborts slave transfer to idle
// - Master port: select, shift, deselect
// - Master port passes bytes unchanged
// - Shift out and capture each bit
// - Full and half duplex supported; code has no half-duplex mode, every byte is both shifted out and captured
// - Clock rate, polarity, phase configurable
// - Exactly one active-low select output
`timescale 1ns/1ps
module spi_master_slave_ports #(
  parameter int DEPTH = spi_bridge_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  // Slave port pins
  input wire logic peripheral_side_clock_in,
  input wire logic peripheral_side_select_n,
  input wire logic peripheral_side_data_in,
  output logic peripheral_side_data_out,
  // Slave port user side
  input wire spi_bridge_pkg::spi_cfg_t slaveCfg,
  input wire logic [7:0] slaveReply,
  output logic [7:0] slaveRxData,
  output logic slaveRxValid,
  output logic slaveBusy,
  // Master port pins
  output logic masterClock,
  output logic masterDataOut,
  input wire logic masterDataIn,
  output logic masterSelect_n,
  // Master port user side
  input wire spi_bridge_pkg::spi_cfg_t masterCfg,
  input wire logic [7:0] masterDiv,
  input wire spi_bridge_pkg::tx_word_t txWord,
  input wire logic txValid,
  output logic txReady,
  output logic [7:0] masterRxData,
  output logic masterRxValid,
  output logic masterBusy
);
  import spi_bridge_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Slave port, link clock domain
  logic sampleClk;
  logic [2:0] bitCnt;
  logic [2:0] outCnt;
  logic [7:0] rxShift;
  logic [7:0] rxHold;
  logic rxToggle;
  logic outBit;
  logic [7:0] replyReg;

  // Fold polarity and phase so the sample edge is always the rising one
  assign sampleClk = peripheral_side_clock_in ^ slaveCfg.cpol ^ slaveCfg.cpha;

  // Sample edge: assemble bytes, cleared while deselected
  always_ff @(posedge sampleClk or posedge peripheral_side_select_n)
  begin
    if (peripheral_side_select_n)
    begin
      bitCnt <= BIT_FIRST;
      rxShift <= 8'h00;
    end
    else
    begin
      bitCnt <= bitCnt + 3'h1;
      rxShift <= shiftIn(rxShift, peripheral_side_data_in, slaveCfg.lsbFirst);
    end
  end

  // Whole byte handed over by a toggle; partial bytes never toggle
  always_ff @(posedge sampleClk or posedge rst)
  begin
    if (rst)
    begin
      rxToggle <= 1'b0;
      rxHold <= 8'h00;
    end
    else if (!peripheral_side_select_n && bitCnt == BIT_LAST)
    begin
      rxHold <= shiftIn(rxShift, peripheral_side_data_in, slaveCfg.lsbFirst);
      rxToggle <= ~rxToggle;
    end
  end

  // Shift edge: next reply bit; phase 0 pre-advances one bit
  always_ff @(negedge sampleClk or posedge peripheral_side_select_n)
  begin
    if (peripheral_side_select_n)
    begin
      outCnt <= BIT_FIRST;
      outBit <= 1'b0;
    end
    else
    begin
      outBit <= pickBit(replyReg, outCnt + {2'b00, ~slaveCfg.cpha},
                        slaveCfg.lsbFirst);
      outCnt <= outCnt + 3'h1;
    end
  end

  // Phase 0 needs the first bit before any clock edge
  assign peripheral_side_data_out =
    (!slaveCfg.cpha && outCnt == BIT_FIRST) ?
    pickBit(replyReg, BIT_FIRST, slaveCfg.lsbFirst) : outBit;

  //////////////////////////////////////////////////////////////////////////
  // Slave port, ref_clk side of the crossing
  logic [2:0] togSync;
  logic [1:0] selSync;

  // Reply byte held for the link side
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      replyReg <= 8'h00;
    else
      replyReg <= slaveReply;
  end

  // Toggle and select synchronisers
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      togSync <= 3'b000;
      selSync <= 2'b11;
    end
    else
    begin
      togSync <= {togSync[1:0], rxToggle};
      selSync <= {selSync[0], peripheral_side_select_n};
    end
  end

  // Received byte out as one-cycle pulse
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      slaveRxValid <= 1'b0;
      slaveRxData <= 8'h00;
      slaveBusy <= 1'b0;
    end
    else
    begin
      slaveRxValid <= togSync[2] ^ togSync[1];
      if (togSync[2] ^ togSync[1])
        slaveRxData <= rxHold;
      slaveBusy <= ~selSync[1];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Master port transmit queue
  tx_word_t fifoOut;
  logic fifoValid;
  logic fifoPop;

  spi_byte_fifo #(
    .WIDTH($bits(tx_word_t)),
    .DEPTH(DEPTH)
  ) u_tx_fifo (
    .clk(ref_clk),
    .rst(rst),
    .inData(txWord),
    .inValid(txValid),
    .inReady(txReady),
    .outData(fifoOut),
    .outValid(fifoValid),
    .outReady(fifoPop)
  );

  //////////////////////////////////////////////////////////////////////////
  // Master port engine
  master_state_t state;
  spi_cfg_t curCfg;
  logic [1:0] misoSync;
  logic [7:0] divCnt;
  logic [3:0] edgeCnt;
  logic [2:0] txIdx;
  logic [7:0] txByte;
  logic [7:0] rxByte;
  logic lastByte;
  logic tick;
  logic sampleNow;

  assign tick = divCnt == 8'h00;
  assign sampleNow = state == M_SHIFT && tick && edgeCnt[0] == curCfg.cpha;
  // Take the next byte when idle, or between bytes of an open transaction
  assign fifoPop = fifoValid &&
    (state == M_IDLE || (state == M_HOLD && tick && !lastByte));

  // Input pin synchroniser
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      misoSync <= 2'b00;
    else
      misoSync <= {misoSync[0], masterDataIn};
  end

  // Sequencer, clock, select and data out
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state <= M_IDLE;
      curCfg <= '0;
      masterClock <= 1'b0;
      masterSelect_n <= 1'b1;
      masterDataOut <= 1'b0;
      divCnt <= 8'h00;
      edgeCnt <= EDGE_FIRST;
      txIdx <= BIT_FIRST;
      txByte <= 8'h00;
      lastByte <= 1'b0;
    end
    else
    begin
      if (state != M_IDLE && !tick)
        divCnt <= divCnt - 8'h01;
      if (fifoPop)
      begin
        // Byte sent as queued, no command decoding
        txByte <= fifoOut.data;
        lastByte <= fifoOut.last;
        masterSelect_n <= 1'b0;
        divCnt <= masterDiv;
        edgeCnt <= EDGE_FIRST;
        state <= M_SETUP;
        if (state == M_IDLE)
          curCfg <= masterCfg;
        if (!(state == M_IDLE ? masterCfg.cpha : curCfg.cpha))
        begin
          masterDataOut <= pickBit(fifoOut.data, BIT_FIRST,
            state == M_IDLE ? masterCfg.lsbFirst : curCfg.lsbFirst);
          txIdx <= 3'h1;
        end
        else
          txIdx <= BIT_FIRST;
      end
      else
      begin
        unique case (state)
          M_IDLE:
          begin
            masterClock <= masterCfg.cpol;
            masterSelect_n <= 1'b1;
          end
          M_SETUP:
            if (tick)
            begin
              state <= M_SHIFT;
              divCnt <= masterDiv;
            end
          M_SHIFT:
            if (tick)
            begin
              masterClock <= ~masterClock;
              edgeCnt <= edgeCnt + 4'h1;
              divCnt <= masterDiv;
              // No shift after the closing edge; MOSI keeps the last bit
              if (edgeCnt[0] != curCfg.cpha && edgeCnt != EDGE_LAST)
              begin
                masterDataOut <= pickBit(txByte, txIdx, curCfg.lsbFirst);
                txIdx <= txIdx + 3'h1;
              end
              if (edgeCnt == EDGE_LAST)
                state <= M_HOLD;
            end
          M_HOLD:
            if (tick && lastByte)
            begin
              masterSelect_n <= 1'b1;
              state <= M_IDLE;
            end
        endcase
      end
    end
  end

  // Capture on sample edges; every byte returned, used or not
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rxByte <= 8'h00;
      masterRxData <= 8'h00;
      masterRxValid <= 1'b0;
      masterBusy <= 1'b0;
    end
    else
    begin
      masterRxValid <= 1'b0;
      masterBusy <= state != M_IDLE || fifoValid;
      if (sampleNow)
        rxByte <= shiftIn(rxByte, misoSync[1], curCfg.lsbFirst);
      if (state == M_SHIFT && tick && edgeCnt == EDGE_LAST)
      begin
        masterRxValid <= 1'b1;
        masterRxData <= sampleNow ?
          shiftIn(rxByte, misoSync[1], curCfg.lsbFirst) : rxByte;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  property p_idleLevel;
    @(posedge ref_clk) disable iff (rst)
    (state == M_IDLE && !fifoPop) |=> masterClock == $past(masterCfg.cpol);
  endproperty
  a_idleLevel: assert property (p_idleLevel)
    else $error("master clock not idle level");

  property p_sampleEdge;
    @(posedge ref_clk) disable iff (rst)
    sampleNow |=> masterClock == sampleLevel(curCfg);
  endproperty
  a_sampleEdge: assert property (p_sampleEdge)
    else $error("sample on wrong clock edge");

  property p_shiftEdge;
    @(posedge ref_clk) disable iff (rst)
    (state == M_SHIFT && tick && !sampleNow) |=>
      masterClock == ~sampleLevel(curCfg);
  endproperty
  a_shiftEdge: assert property (p_shiftEdge)
    else $error("data change on wrong clock edge");

  property p_selFall;
    @(posedge ref_clk) disable iff (rst)
    $fell(masterSelect_n) |-> $past(fifoValid) && $past(state) == M_IDLE;
  endproperty
  a_selFall: assert property (p_selFall)
    else $error("select asserted without queued byte");

  property p_oneSelect;
    @(posedge ref_clk) disable iff (rst)
    (state == M_SHIFT) |-> !masterSelect_n;
  endproperty
  a_oneSelect: assert property (p_oneSelect)
    else $error("clocking without select");

  property p_divHalf;
    @(posedge ref_clk) disable iff (rst)
    (state == M_SHIFT && $changed(masterClock)) |->
      $past(divCnt) == 8'h00;
  endproperty
  a_divHalf: assert property (p_divHalf)
    else $error("clock edge before divider expired");

  property p_passThrough;
    @(posedge ref_clk) disable iff (rst)
    fifoPop |=> txByte == $past(fifoOut.data);
  endproperty
  a_passThrough: assert property (p_passThrough)
    else $error("transmit byte altered");

  property p_edgeCount;
    @(posedge ref_clk) disable iff (rst)
    (state == M_HOLD && $past(state) == M_SHIFT) |->
      masterRxValid && edgeCnt == EDGE_FIRST && txIdx == BIT_FIRST;
  endproperty
  a_edgeCount: assert property (p_edgeCount)
    else $error("byte did not span sixteen edges");

  property p_slaveAbort;
    @(posedge ref_clk) disable iff (rst)
    peripheral_side_select_n |-> bitCnt == BIT_FIRST && outCnt == BIT_FIRST;
  endproperty
  a_slaveAbort: assert property (p_slaveAbort)
    else $error("slave counters not cleared while deselected");

  property p_slaveWrap;
    @(posedge sampleClk) disable iff (peripheral_side_select_n)
    (bitCnt == BIT_LAST) |=> bitCnt == BIT_FIRST && $changed(rxToggle);
  endproperty
  a_slaveWrap: assert property (p_slaveWrap)
    else $error("slave byte not closed after eight bits");
endmodule

// >>> spi_bridge_pkg.sv
// Shared constants, carriers and helpers for the SPI slave/master bridge.
// Assumes one ref_clk domain plus the externally driven slave clock.
package spi_bridge_pkg;
  localparam int BYTE_BITS = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int DIV_WIDTH = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [3:0] EDGE_LAST = 4'hF;
  localparam logic [3:0] EDGE_FIRST = 4'h0;

  // Clock mode and bit order of one port
  typedef struct packed {
    logic lsbFirst;
    logic cpol;
    logic cpha;
  } spi_cfg_t;

  // Byte queued for the master port; last closes the transaction
  typedef struct packed {
    logic last;
    logic [BYTE_BITS-1:0] data;
  } tx_word_t;

  typedef enum logic [1:0] {M_IDLE, M_SETUP, M_SHIFT, M_HOLD} master_state_t;

  // Clock level reached by the edge on which data is sampled
  function automatic logic sampleLevel(input spi_cfg_t c);
    return ~(c.cpol ^ c.cpha);
  endfunction

  // Bit of a byte in transmit order
  function automatic logic pickBit(input logic [7:0] b, input logic [2:0] i,
                                   input logic lsb);
    return lsb ? b[i] : b[3'h7 - i];
  endfunction

  // Shift one received bit into a byte in transmit order
  function automatic logic [7:0] shiftIn(input logic [7:0] b, input logic d,
                                         input logic lsb);
    return lsb ? {d, b[7:1]} : {b[6:0], d};
  endfunction
endpackage

// >>> spi_byte_fifo.sv
// Byte FIFO with registered output stage and registered ready.
// Assumes DEPTH is a power of two; single clock, synchronous reset.
`timescale 1ns/1ps
module spi_byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0] NONE = '0;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic fill;

  // Handshakes on both sides
  assign push = inValid && inReady;
  assign fill = (count != NONE) && (!outValid || outReady);
  always_comb
  begin
    next_count = count;
    if (push && !fill)
      next_count = count + 1'b1;
    else if (fill && !push)
      next_count = count - 1'b1;
  end

  // Storage array and write pointer
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wrPtr] <= inData;
    if (rst)
      wrPtr <= '0;
    else if (push)
      wrPtr <= wrPtr + 1'b1;
  end

  // Occupancy and ready, both registered
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count <= NONE;
      inReady <= 1'b0;
    end
    else
    begin
      count <= next_count;
      inReady <= next_count != FULL;
    end
  end

  // Output register stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdPtr <= '0;
      outValid <= 1'b0;
      outData <= '0;
    end
    else if (fill)
    begin
      outData <= mem[rdPtr];
      outValid <= 1'b1;
      rdPtr <= rdPtr + 1'b1;
    end
    else if (outReady)
      outValid <= 1'b0;
  end
endmodule

// >>> spi_far_slave_model.sv
// Behavioural SPI slave hanging on the master port pins.
// Assumes cfg is steady per frame and masterDiv keeps MISO hold >= 3 cycles.
`timescale 1ns/1ps
module spi_far_slave_model (
  input wire logic sclk,
  input wire logic selN,
  input wire logic mosi,
  input wire spi_bridge_pkg::spi_cfg_t cfg,
  input wire logic [7:0] reply,
  output logic miso
);
  import spi_bridge_pkg::*;
  logic [7:0] acc;
  logic [7:0] gotQ[$];
  int cnt;
  time tFall;
  initial miso = 1'b1;
  ////////////////////////////////////////////////////////////
  // Frame start: phase 0 presents the first bit before any edge
  always @(negedge selN)
  begin
    cnt = 0;
    tFall = $time;
    if (!cfg.cpha)
      miso = cfg.lsbFirst ? reply[0] : reply[7];
  end
  // Released line shows the inverse of its last value
  always @(posedge selN)
    miso = ~miso;
  // Sample on one edge, shift on the other; ignore the select edge step
  always @(sclk)
    if (selN === 1'b0 && $time != tFall)
    begin
      if (sclk === ~(cfg.cpol ^ cfg.cpha))
      begin
        acc = cfg.lsbFirst ? {mosi, acc[7:1]} : {acc[6:0], mosi};
        cnt++;
        if (cnt % 8 == 0)
          gotQ.push_back(acc);
      end
      else
        miso = cfg.lsbFirst ? reply[cnt % 8] : reply[7 - cnt % 8];
    end
endmodule

// >>> tb_spi_master_slave_ports.sv
// Self-checking bench for the SPI slave port and SPI master port.
// Assumes the package and the far-side slave model are compiled first.
`timescale 1ns/1ps
module tb_spi_master_slave_ports;
  import spi_bridge_pkg::*;
  logic ref_clk = 1'b0;
  // Reset and select start unknown so their first rise clears the link side
  logic rst;
  logic sClk = 1'b0;
  logic sSelN;
  logic sMosi = 1'b0;
  logic sMiso, slaveRxValid, slaveBusy, masterClock, masterDataOut;
  logic masterDataIn, masterSelect_n, txReady, masterRxValid, masterBusy;
  logic [7:0] slaveRxData, masterRxData;
  spi_cfg_t slaveCfg = '0;
  spi_cfg_t masterCfg = '0;
  logic [7:0] slaveReply = 8'h00;
  logic [7:0] masterDiv = 8'h02;
  logic [7:0] farReply = 8'h00;
  tx_word_t txWord = '0;
  logic txValid = 1'b0;
  logic [7:0] sRxQ[$], mRxQ[$];
  logic [31:0] seed = 32'hA30EF075;
  int failures = 0;
  int n_compared = 0;
  int gap = 1000;
  int minGap = 1000;
  logic lastClk = 1'b0;

  spi_master_slave_ports spi_master_slave_ports_inst (
    .ref_clk(ref_clk), .rst(rst), .peripheral_side_clock_in(sClk),
    .peripheral_side_select_n(sSelN), .peripheral_side_data_in(sMosi),
    .peripheral_side_data_out(sMiso), .slaveCfg(slaveCfg),
    .slaveReply(slaveReply), .slaveRxData(slaveRxData),
    .slaveRxValid(slaveRxValid), .slaveBusy(slaveBusy),
    .masterClock(masterClock), .masterDataOut(masterDataOut),
    .masterDataIn(masterDataIn), .masterSelect_n(masterSelect_n),
    .masterCfg(masterCfg), .masterDiv(masterDiv), .txWord(txWord),
    .txValid(txValid), .txReady(txReady), .masterRxData(masterRxData),
    .masterRxValid(masterRxValid), .masterBusy(masterBusy));
  spi_far_slave_model spi_far_slave_model_inst (
    .sclk(masterClock), .selN(masterSelect_n), .mosi(masterDataOut),
    .cfg(masterCfg), .reply(farReply), .miso(masterDataIn));

  ////////////////////////////////////////////////////////////
  // Clock, received-byte monitors and master clock half-period meter
  always #2 ref_clk = ~ref_clk;
  always @(negedge ref_clk)
  begin
    if (slaveRxValid === 1'b1)
      sRxQ.push_back(slaveRxData);
    if (masterRxValid === 1'b1)
      mRxQ.push_back(masterRxData);
    if (masterClock !== lastClk)
    begin
      if (masterSelect_n === 1'b0 && gap < minGap)
        minGap = gap;
      gap = 1;
    end
    else
      gap++;
    lastClk = masterClock;
  end

  ////////////////////////////////////////////////////////////
  // Helpers: random source, comparison, verdict
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed[7:0];
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // External master on the slave port; link clock 160 ns, stopped idle
  task automatic slave_frame(input int nBytes, input bit cut);
    logic [7:0] b, m;
    logic [7:0] expQ[$];
    int nb;
    sRxQ.delete();
    sSelN = 1'b0;
    for (int k = 0; k < nBytes; k++)
    begin
      b = rnd();
      nb = (cut && k == nBytes - 1) ? 3 : 8;
      for (int i = 0; i < nb; i++)
      begin
        if (slaveCfg.cpha)
          #80 sClk = ~sClk;
        sMosi = slaveCfg.lsbFirst ? b[i] : b[7 - i];
        #80;
        m[i] = sMiso;
        sClk = ~sClk;
        if (!slaveCfg.cpha)
          #80 sClk = ~sClk;
      end
      if (nb == 8)
      begin
        expQ.push_back(b);
        for (int i = 0; i < 8; i++)
          check(m[i], slaveReply[slaveCfg.lsbFirst ? i : 7 - i]);
      end
    end
    check(slaveBusy, 1'b1);
    #80 sSelN = 1'b1;
    repeat (20) @(negedge ref_clk);
    check(slaveBusy, 1'b0);
    check(sRxQ.size(), expQ.size());
    foreach (expQ[k])
      check(sRxQ[k], expQ[k]);
    $display("slave frame of %0d bytes done", nBytes);
  endtask

  ////////////////////////////////////////////////////////////
  // Push bytes into the master port and compare both directions
  task automatic master_run(input int n);
    logic [7:0] sent[$];
    int t;
    bit sawFull;
    sawFull = 0;
    minGap = 1000;
    mRxQ.delete();
    spi_far_slave_model_inst.gotQ.delete();
    for (int k = 0; k < n; k++)
    begin
      @(negedge ref_clk);
      txWord.data = rnd();
      txWord.last = (k == n - 1);
      sent.push_back(txWord.data);
      txValid = 1'b1;
      t = 0;
      while (txReady !== 1'b1 && t < 5000)
      begin
        sawFull = 1;
        @(negedge ref_clk);
        t++;
      end
    end
    @(negedge ref_clk);
    txValid = 1'b0;
    t = 0;
    while ((spi_far_slave_model_inst.gotQ.size() < n
            || masterSelect_n !== 1'b1) && t < 20000)
    begin
      @(negedge ref_clk);
      t++;
    end
    repeat (4) @(negedge ref_clk);
    check(spi_far_slave_model_inst.gotQ.size(), n);
    foreach (sent[k])
      check(spi_far_slave_model_inst.gotQ[k], sent[k]);
    check(mRxQ.size(), n);
    foreach (mRxQ[k])
      check(mRxQ[k], farReply);
    check(minGap, masterDiv + 1);
    check(masterClock, masterCfg.cpol);
    check(masterSelect_n, 1'b1);
    check(masterBusy, 1'b0);
    if (n > 16)
      check(sawFull, 1'b1);
    $display("master run of %0d bytes done", n);
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence: every mode on both ports, aborts, FIFO overflow
  initial
  begin
    logic [7:0] r;
    // Rising reset and select clear the link-clocked flops before any edge
    #1;
    rst = 1'b1;
    sSelN = 1'b1;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    for (int m = 0; m < 4; m++)
    begin
      r = rnd();
      slaveCfg = {r[0], m[1:0]};
      masterCfg = {r[1], m[1:0]};
      masterDiv = 8'h02 + {5'h00, r[4:2]};
      slaveReply = rnd();
      farReply = rnd();
      #3 sClk = slaveCfg.cpol;
      #50;
      slave_frame(3, 0);
      slave_frame(2, 1);
      slave_frame(1, 0);
      master_run(m == 0 ? 1 : 3);
    end
    masterDiv = 8'h09;
    master_run(20);
    complete_run();
  end

  // Watchdog for a hung handshake
  initial
  begin
    #200000;
    failures++;
    complete_run();
  end
endmodule
